// File: common/rmpc_pkg.sv
// Types shared by the packet control block
package rmpc_pkg;
	`include "rmpc_regs.svh"
	typedef struct packed {
		logic [15:0] address_mask;
		logic [15:0] dest_addr;
		logic [7:0]  parity_select;
		logic [7:0]  power_up_mode;
		logic [7:0]  pin_wake_enable;
		logic [7:0]  sleep_mode_select;
		logic [15:0] inactivity_time;
		logic [7:0]  delay_slot_count;
		logic [7:0]  retry_limit;
		logic [15:0] packet_silence_timeout;
	} rmpc_cfg_s;
	localparam rmpc_cfg_s RMPC_CFG_DEFAULT = '{`RMPC_DEF_MASK, `RMPC_DEF_DEST, `RMPC_DEF_PARITY,
		`RMPC_DEF_PWRUP, `RMPC_DEF_PINWAKE, `RMPC_DEF_SLEEPSEL, `RMPC_DEF_INACT,
		`RMPC_DEF_SLOTS, `RMPC_DEF_RETRY, `RMPC_DEF_SILENCE};
	typedef enum logic [1:0] {
		RMPC_TX_IDLE = 2'b00,
		RMPC_TX_SEND = 2'b01,
		RMPC_TX_BACK = 2'b10
	} rmpc_tx_e;
endpackage

// File: common/rmpc_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef RMPC_REGS_SVH
`define RMPC_REGS_SVH
// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define RMPC_IDX_RESTORE  7'h0E
`define RMPC_IDX_MASK     7'h12
`define RMPC_IDX_RETRY    7'h18
`define RMPC_IDX_SLOTS    7'h19
`define RMPC_IDX_PINWAKE  7'h1D
`define RMPC_IDX_PWRUP    7'h1E
`define RMPC_IDX_SILENCE  7'h21
`define RMPC_IDX_PARITY   7'h23
`define RMPC_IDX_DEST     7'h30
`define RMPC_IDX_SLEEPSEL 7'h31
`define RMPC_IDX_INACT    7'h32
`define RMPC_IDX_CTRL     7'h40
`define RMPC_IDX_STAT     7'h41
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define RMPC_CTRL_PERSIST  0
`define RMPC_CTRL_EXIT_CMD 1
`define RMPC_CTRL_ENTER_CMD 2
// ----------------------------------------
// Factory defaults
// ----------------------------------------
`define RMPC_DEF_MASK     16'hFFFF
`define RMPC_DEF_DEST     16'h0000
`define RMPC_DEF_PARITY   8'h00
`define RMPC_DEF_PWRUP    8'h00
`define RMPC_DEF_PINWAKE  8'h00
`define RMPC_DEF_SLEEPSEL 8'h00
`define RMPC_DEF_INACT    16'h0064
`define RMPC_DEF_SLOTS    8'h00
`define RMPC_DEF_RETRY    8'h00
`define RMPC_DEF_SILENCE  16'h0000
`define RMPC_PARITY_MAX   8'h04
// ----------------------------------------
// Timing
// ----------------------------------------
`define RMPC_CLK_HZ       20000000
`define RMPC_SLOT_MS      38
`define RMPC_SLOT_CYC     (`RMPC_SLOT_MS * (`RMPC_CLK_HZ / 1000))
`define RMPC_SILENCE_US   200
`define RMPC_SILENCE_CYC  (`RMPC_SILENCE_US * (`RMPC_CLK_HZ / 1000000))
`define RMPC_INACT_MS     1
`define RMPC_INACT_CYC    (`RMPC_INACT_MS * (`RMPC_CLK_HZ / 1000))
`endif

// File: common/rmpc_tmr_if.sv
// Start and done handshake between the controller and a unit timer
`timescale 1ns/100ps
interface rmpc_tmr_if;
	logic        start;
	logic [15:0] units;
	logic        busy;
	logic        done;
	modport ctl (output start, output units, input busy, input done);
	modport tmr (input start, input units, output busy, output done);
endinterface

// File: rtl/rmpc_lfsr.sv
// Free-running pseudo-random byte source
`timescale 1ns/100ps
module rmpc_lfsr (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// Random value
	output logic [7:0]      rnd
);
	logic [15:0] sr_q;

	assign rnd = sr_q[7:0];

	// Taps 16,14,13,11 give a maximal length sequence
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sr_q <= 16'hACE1;
		end else begin
			sr_q <= {sr_q[14:0], sr_q[15] ^ sr_q[13] ^ sr_q[12] ^ sr_q[10]};
		end
	end
endmodule

// File: rtl/rmpc_top.sv
// Packet parameter control for a serial radio modem
`timescale 1ns/100ps
`include "rmpc_regs.svh"
module rmpc_top
	import rmpc_pkg::*;
#(
	parameter int SLOT_CYC = `RMPC_SLOT_CYC,
	parameter int INACT_CYC = `RMPC_INACT_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        nv_init,
	// AXI4-Lite slave
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Radio receive stream
	input  wire logic        rx_valid,
	input  wire logic        rx_first,
	input  wire logic [15:0] rx_dest,
	input  wire logic [7:0]  rx_data,
	// Serial data output
	output logic             ser_valid,
	output logic [7:0]       ser_data,
	// Serial data input
	input  wire logic        host_valid,
	// Radio transmit control
	output logic             tx_start,
	input  wire logic        tx_done,
	input  wire logic        tx_ack,
	input  wire logic        force_delay,
	// Pins and modes
	input  wire logic        mode_pin_3,
	output logic [7:0]       parity_select,
	output logic             cmd_mode,
	output logic             asleep
);
	import rmpc_pkg::*;

	rmpc_cfg_s   cfg_q;
	rmpc_cfg_s   nv_q;
	rmpc_tx_e    tx_q;
	logic [1:0]  pin_sync_q;
	logic        boot_q;
	logic        restore_q;
	logic [6:0]  aw_idx_q;
	logic        aw_full_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_full_q;
	logic        accept_q;
	logic        pending_q;
	logic        go_q;
	logic [7:0]  sent_q;
	logic [31:0] inact_pre_q;
	logic [15:0] inact_left_q;
	logic [7:0]  rnd;
	logic [15:0] masked;
	logic        hit;
	logic        pin_low;
	logic        cyclic;
	logic        do_wr;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_word;
	logic [31:0] wv;
	logic [6:0]  ar_idx;

	rmpc_tmr_if  sil_if ();
	rmpc_tmr_if  bk_if ();

	rmpc_unit_timer #(.UNIT_CYC(`RMPC_SILENCE_CYC)) u_silence (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tm      (sil_if)
	);
	// Delay slot length
	// 38 ms slots
	rmpc_unit_timer #(.UNIT_CYC(SLOT_CYC)) u_backoff (
		.ref_clk (ref_clk),
		.reset   (reset),
		.tm      (bk_if)
	);
	rmpc_lfsr u_lfsr (
		.ref_clk (ref_clk),
		.reset   (reset),
		.rnd     (rnd)
	);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_sync_q <= 2'b11;
		end else begin
			pin_sync_q <= {pin_sync_q[0], mode_pin_3};
		end
	end
	assign pin_low = ~pin_sync_q[1];
	assign cyclic = cfg_q.sleep_mode_select != 8'h00;

	// ----------------------------------------
	// Register bus write side
	// ----------------------------------------
	assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wv = w_data_q;

	// Address and data are taken in either order
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			aw_idx_q      <= 7'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_full_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_full_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_q  <= s_axi_awaddr[8:2];
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
			end
			if (do_wr) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Index decode
	// ----------------------------------------
	function automatic logic known_idx(input logic [6:0] idx);
		known_idx = idx == `RMPC_IDX_MASK || idx == `RMPC_IDX_PARITY || idx == `RMPC_IDX_PWRUP
			|| idx == `RMPC_IDX_PINWAKE || idx == `RMPC_IDX_RESTORE || idx == `RMPC_IDX_SLOTS
			|| idx == `RMPC_IDX_SILENCE || idx == `RMPC_IDX_RETRY || idx == `RMPC_IDX_DEST
			|| idx == `RMPC_IDX_SLEEPSEL || idx == `RMPC_IDX_INACT || idx == `RMPC_IDX_CTRL
			|| idx == `RMPC_IDX_STAT;
	endfunction
	// Out-of-range values are refused with an error response
	always_comb begin
		wr_ok = known_idx(aw_idx_q) && aw_idx_q != `RMPC_IDX_STAT;
		if (aw_idx_q == `RMPC_IDX_PARITY && w_strb_q[0] && wv[7:0] > `RMPC_PARITY_MAX) begin
			wr_ok = 1'b0;
		end else if ((aw_idx_q == `RMPC_IDX_PWRUP || aw_idx_q == `RMPC_IDX_PINWAKE)
			&& w_strb_q[0] && wv[7:1] != 7'h00) begin
			wr_ok = 1'b0;
		end
	end

	// ----------------------------------------
	// Working and stored configuration
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_q     <= RMPC_CFG_DEFAULT;
			restore_q <= 1'b1;
		end else begin
			restore_q <= 1'b0;
			// Working copy comes back from storage after a reset
			if (restore_q) begin
				cfg_q <= nv_q;
			end else if (do_wr && wr_ok) begin
				if (aw_idx_q == `RMPC_IDX_MASK) begin
					if (w_strb_q[0]) cfg_q.address_mask[7:0] <= wv[7:0];
					if (w_strb_q[1]) cfg_q.address_mask[15:8] <= wv[15:8];
				end else if (aw_idx_q == `RMPC_IDX_DEST) begin
					if (w_strb_q[0]) cfg_q.dest_addr[7:0] <= wv[7:0];
					if (w_strb_q[1]) cfg_q.dest_addr[15:8] <= wv[15:8];
				end else if (aw_idx_q == `RMPC_IDX_PARITY) begin
					if (w_strb_q[0]) cfg_q.parity_select <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_PWRUP) begin
					if (w_strb_q[0]) cfg_q.power_up_mode <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_PINWAKE) begin
					if (w_strb_q[0]) cfg_q.pin_wake_enable <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_SLEEPSEL) begin
					if (w_strb_q[0]) cfg_q.sleep_mode_select <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_INACT) begin
					if (w_strb_q[0]) cfg_q.inactivity_time[7:0] <= wv[7:0];
					if (w_strb_q[1]) cfg_q.inactivity_time[15:8] <= wv[15:8];
				end else if (aw_idx_q == `RMPC_IDX_SLOTS) begin
					if (w_strb_q[0]) cfg_q.delay_slot_count <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_RETRY) begin
					if (w_strb_q[0]) cfg_q.retry_limit <= wv[7:0];
				end else if (aw_idx_q == `RMPC_IDX_SILENCE) begin
					if (w_strb_q[0]) cfg_q.packet_silence_timeout[7:0] <= wv[7:0];
					if (w_strb_q[1]) cfg_q.packet_silence_timeout[15:8] <= wv[15:8];
				end else if (aw_idx_q == `RMPC_IDX_RESTORE) begin
					cfg_q <= RMPC_CFG_DEFAULT;
				end
			end
		end
	end

	// Storage is cleared only by its own power-on input, never by reset
	always_ff @(posedge ref_clk) begin
		if (nv_init) begin
			nv_q <= RMPC_CFG_DEFAULT;
		end else if (do_wr && aw_idx_q == `RMPC_IDX_CTRL && w_strb_q[0] && wv[`RMPC_CTRL_PERSIST]) begin
			nv_q <= cfg_q;
		end
	end

	// ----------------------------------------
	// Register bus read side
	// ----------------------------------------
	assign ar_idx = s_axi_araddr[8:2];

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (ar_idx == `RMPC_IDX_MASK) begin
			rd_word[15:0] = cfg_q.address_mask;
		end else if (ar_idx == `RMPC_IDX_DEST) begin
			rd_word[15:0] = cfg_q.dest_addr;
		end else if (ar_idx == `RMPC_IDX_PARITY) begin
			rd_word[7:0] = cfg_q.parity_select;
		end else if (ar_idx == `RMPC_IDX_PWRUP) begin
			rd_word[7:0] = cfg_q.power_up_mode;
		end else if (ar_idx == `RMPC_IDX_PINWAKE) begin
			rd_word[7:0] = cfg_q.pin_wake_enable;
		end else if (ar_idx == `RMPC_IDX_SLEEPSEL) begin
			rd_word[7:0] = cfg_q.sleep_mode_select;
		end else if (ar_idx == `RMPC_IDX_INACT) begin
			rd_word[15:0] = cfg_q.inactivity_time;
		end else if (ar_idx == `RMPC_IDX_SLOTS) begin
			rd_word[7:0] = cfg_q.delay_slot_count;
		end else if (ar_idx == `RMPC_IDX_RETRY) begin
			rd_word[7:0] = cfg_q.retry_limit;
		end else if (ar_idx == `RMPC_IDX_SILENCE) begin
			rd_word[15:0] = cfg_q.packet_silence_timeout;
		end else if (ar_idx == `RMPC_IDX_STAT) begin
			rd_word[15:0] = {sent_q, 2'b00, tx_q, pending_q, bk_if.busy, asleep, cmd_mode};
		end else if (ar_idx == `RMPC_IDX_RESTORE || ar_idx == `RMPC_IDX_CTRL) begin
			rd_word = 32'h0000_0000;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Command mode and cyclic sleep
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			boot_q   <= 1'b1;
			cmd_mode <= 1'b0;
		end else begin
			boot_q <= restore_q;
			if (boot_q) begin
				// power-up mode picks idle or command
				cmd_mode <= cfg_q.power_up_mode[0];
			end else if (cfg_q.power_up_mode[0] && cfg_q.sleep_mode_select == 8'h01 && pin_low && asleep) begin
				// low mode pin wakes into command mode
				cmd_mode <= 1'b1;
			end else if (do_wr && aw_idx_q == `RMPC_IDX_CTRL && w_strb_q[0]) begin
				if (wv[`RMPC_CTRL_ENTER_CMD]) cmd_mode <= 1'b1;
				else if (wv[`RMPC_CTRL_EXIT_CMD]) cmd_mode <= 1'b0;
			end
		end
	end

	// Inactivity count restarts on any traffic or on a held-low pin
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			inact_pre_q  <= 32'h0000_0000;
			inact_left_q <= `RMPC_DEF_INACT;
			asleep       <= 1'b0;
		end else if (!cyclic || host_valid || rx_valid || cmd_mode || tx_q != RMPC_TX_IDLE
			|| (cfg_q.pin_wake_enable[0] && pin_low)) begin
			// pin low keeps the device awake
			inact_pre_q  <= 32'h0000_0000;
			inact_left_q <= cfg_q.inactivity_time;
			asleep       <= 1'b0;
		end else if (inact_left_q != 16'h0000) begin
			// stay active for the inactivity time
			if (inact_pre_q == 32'(INACT_CYC - 1)) begin
				inact_pre_q  <= 32'h0000_0000;
				inact_left_q <= inact_left_q - 16'h0001;
			end else begin
				inact_pre_q <= inact_pre_q + 32'h0000_0001;
			end
		end else begin
			asleep <= !pending_q;
		end
	end

	// ----------------------------------------
	// Receive address filter
	// ----------------------------------------
	// AND with mask
	assign masked = rx_dest & cfg_q.address_mask;
	assign hit = masked == cfg_q.dest_addr || masked == cfg_q.address_mask;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			accept_q  <= 1'b0;
			ser_valid <= 1'b0;
			ser_data  <= 8'h00;
		end else begin
			ser_valid <= rx_valid && (rx_first ? hit : accept_q);
			if (rx_valid) begin
				ser_data <= rx_data;
			end
			if (rx_valid && rx_first) begin
				accept_q <= hit;
			end
		end
	end

	// ----------------------------------------
	// Packetization and retransmission
	// ----------------------------------------
	assign sil_if.start = host_valid;
	assign sil_if.units = cfg_q.packet_silence_timeout;

	// Set wins over clear for the pending and go flags
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pending_q <= 1'b0;
			go_q      <= 1'b0;
		end else begin
			if (host_valid) begin
				pending_q <= 1'b1;
			end else if (tx_start) begin
				pending_q <= 1'b0;
			end
			if (sil_if.done && pending_q) begin
				go_q <= 1'b1;
			end else if (tx_start || host_valid) begin
				go_q <= 1'b0;
			end
		end
	end

	// random slot count from the generator
	assign bk_if.units = (cfg_q.delay_slot_count == 8'h00) ? 16'h0000
		: {8'h00, rnd % cfg_q.delay_slot_count};

	always_comb begin
		bk_if.start = 1'b0;
		if (tx_q == RMPC_TX_IDLE && force_delay) begin
			bk_if.start = 1'b1;
		end else if (tx_q == RMPC_TX_SEND && tx_done && !tx_ack && cfg_q.retry_limit != 8'h00
			&& sent_q < cfg_q.retry_limit) begin
			bk_if.start = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_q     <= RMPC_TX_IDLE;
			tx_start <= 1'b0;
			sent_q   <= 8'h00;
		end else begin
			tx_start <= 1'b0;
			case (tx_q)
				RMPC_TX_IDLE: begin
					if (force_delay) begin
						// Old send count must not turn a forced delay into a resend
						sent_q <= 8'h00;
						tx_q   <= RMPC_TX_BACK;
					end else if (go_q && !tx_start) begin
						tx_start <= 1'b1;
						sent_q   <= 8'h01;
						tx_q     <= RMPC_TX_SEND;
					end
				end
				RMPC_TX_SEND: begin
					if (tx_done) begin
						// resend until the total send count reaches the retry limit
						tx_q <= bk_if.start ? RMPC_TX_BACK : RMPC_TX_IDLE;
					end
				end
				RMPC_TX_BACK: begin
					if (bk_if.done) begin
						if (sent_q != 8'h00 && !go_q) begin
							tx_start <= 1'b1;
							sent_q   <= sent_q + 8'h01;
							tx_q     <= RMPC_TX_SEND;
						end else begin
							sent_q <= 8'h00;
							tx_q   <= RMPC_TX_IDLE;
						end
					end
				end
				default: begin
					tx_q <= RMPC_TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			parity_select <= `RMPC_DEF_PARITY;
		end else begin
			parity_select <= cfg_q.parity_select;
		end
	end
endmodule

// File: rtl/rmpc_unit_timer.sv
// Timer counting a number of fixed-length units
`timescale 1ns/100ps
module rmpc_unit_timer #(
	parameter int UNIT_CYC = 4000
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// Controller side
	rmpc_tmr_if.tmr   tm
);
	logic [31:0] pre_q;
	logic [15:0] left_q;
	logic        busy_q;
	logic        done_q;

	assign tm.busy = busy_q;
	assign tm.done = done_q;

	// A new start restarts the count even while busy
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pre_q  <= 32'h0000_0000;
			left_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tm.start) begin
				pre_q  <= 32'h0000_0000;
				left_q <= tm.units;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (left_q == 16'h0000) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else if (pre_q == 32'(UNIT_CYC - 1)) begin
					pre_q  <= 32'h0000_0000;
					left_q <= left_q - 16'h0001;
				end else begin
					pre_q <= pre_q + 32'h0000_0001;
				end
			end
		end
	end
endmodule

// File: testbench/rmpc_radio_model.sv
// Radio side model: ends each transmission after a set lag
`timescale 1ns/100ps
module rmpc_radio_model #(
	parameter int LAG = 8
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// Transmit handshake
	input  wire logic tx_start,
	input  wire logic ack_en,
	output logic      tx_done,
	output logic      tx_ack
);
	int cnt;
	always @(posedge ref_clk) begin
		if (reset) begin
			cnt <= 0;
			tx_done <= 1'b0;
			tx_ack <= 1'b0;
		end else begin
			tx_done <= (cnt == 1);
			// Ack only means something with done, so toggle it otherwise
			tx_ack <= (cnt == 1) ? ack_en : ~tx_ack;
			cnt <= tx_start ? LAG : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule

// File: testbench/rmpc_top_assertions.sv
// Port-level checks for the packet control block
`timescale 1ns/100ps
module rmpc_top_assertions (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// Watched ports
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_data,
	input wire logic        ser_valid,
	input wire logic [7:0]  ser_data,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        tx_start,
	input wire logic        cmd_mode,
	input wire logic [7:0]  parity_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_quiet_release: assert property ($fell(reset) |-> !ser_valid && !tx_start && !cmd_mode)
		else $error("output active at reset release");
	a_ser_cause: assert property (ser_valid |-> $past(rx_valid) && ser_data == $past(rx_data))
		else $error("serial byte without matching radio byte");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_resp_soon: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_tx_pulse: assert property (tx_start |=> !tx_start)
		else $error("transmit start longer than one cycle");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read address ready held");
	a_parity_range: assert property (parity_select <= 8'h04)
		else $error("parity setting out of range");
endmodule

// File: testbench/tb.sv
// Self-checking bench for the packet control block
`timescale 1ns/100ps
`include "rmpc_regs.svh"
module tb;
	logic        ref_clk, reset, nv_init, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        rx_valid, rx_first, ser_valid, host_valid, tx_start, tx_done, tx_ack, force_delay;
	logic        mode_pin_3, cmd_mode, asleep, ack_en;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  rx_data, ser_data, parity_select;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [15:0] rx_dest;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          errors, n_tests, cyc, n_tx, k;
	rmpc_top #(.SLOT_CYC(20), .INACT_CYC(4)) rmpc_top_inst (.*);
	rmpc_radio_model #(.LAG(8)) rmpc_radio_model_inst (.*);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [6:0] idx, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= {1'b0, idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input string nm, input logic [6:0] idx, input logic [31:0] exp);
		@(posedge ref_clk);
		s_axi_araddr <= {1'b0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		resp = s_axi_rresp;
		chk(nm, s_axi_rdata, exp);
	endtask
	task rx(input logic [15:0] dst, input logic pass);
		@(posedge ref_clk);
		rx_valid <= 1'b1;
		rx_first <= 1'b1;
		rx_dest <= dst;
		rx_data <= dst[7:0] ^ 8'h5A;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_first <= 1'b0;
		@(posedge ref_clk);
		chk("ser_valid", ser_valid, pass);
		if (pass) chk("ser_data", ser_data, {24'h00_0000, dst[7:0] ^ 8'h5A});
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (tx_start === 1'b1) n_tx <= n_tx + 1;
		// Whole run needs about 5000 cycles
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{rx_valid, rx_first, host_valid, force_delay, ack_en} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_dest, rx_data} = '0;
		s_axi_wstrb = 4'hF;
		mode_pin_3 = 1'b1;
		nv_init = 1'b1;
		reset = 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		nv_init <= 1'b0;
		rd("mask", `RMPC_IDX_MASK, 32'h0000_FFFF);
		rd("parity", `RMPC_IDX_PARITY, 32'h0000_0000);
		rd("pwrup", `RMPC_IDX_PWRUP, 32'h0000_0000);
		rd("pinwake", `RMPC_IDX_PINWAKE, 32'h0000_0000);
		rd("slots", `RMPC_IDX_SLOTS, 32'h0000_0000);
		rd("silence", `RMPC_IDX_SILENCE, 32'h0000_0000);
		chk("cmd_mode", cmd_mode, 1'b0);
		$display("test defaults done");
		wr(`RMPC_IDX_PARITY, 32'h0000_0005);
		chk("parity resp", resp, 2'b10);
		wr(`RMPC_IDX_PINWAKE, 32'h0000_0002);
		chk("pinwake resp", resp, 2'b10);
		wr(`RMPC_IDX_PWRUP, 32'h0000_0002);
		chk("pwrup resp", resp, 2'b10);
		wr(`RMPC_IDX_PARITY, 32'h0000_0004);
		chk("parity ok", resp, 2'b00);
		rd("parity", `RMPC_IDX_PARITY, 32'h0000_0004);
		chk("parity pins", parity_select, 8'h04);
		wr(`RMPC_IDX_SILENCE, 32'h0001_ABCD);
		rd("silence", `RMPC_IDX_SILENCE, 32'h0000_ABCD);
		wr(`RMPC_IDX_SLOTS, 32'h0000_00FF);
		rd("slots", `RMPC_IDX_SLOTS, 32'h0000_00FF);
		wr(7'h7F, 32'h0000_0001);
		chk("unmapped resp", resp, 2'b10);
		rd("unmapped", 7'h7F, 32'h0000_0000);
		chk("unmapped rresp", resp, 2'b10);
		$display("test settings done");
		wr(`RMPC_IDX_DEST, 32'h0000_0012);
		wr(`RMPC_IDX_MASK, 32'h0000_00FF);
		rx(16'hAB12, 1'b1);
		rx(16'h0034, 1'b0);
		rx(16'h12FF, 1'b1);
		$display("test filter done");
		wr(`RMPC_IDX_RETRY, 32'h0000_0002);
		wr(`RMPC_IDX_SLOTS, 32'h0000_0001);
		wr(`RMPC_IDX_SILENCE, 32'h0000_0001);
		n_tx = 0;
		host_valid <= 1'b1;
		@(posedge ref_clk);
		host_valid <= 1'b0;
		for (k = 0; n_tx == 0 && k < 5000; k++) @(posedge ref_clk);
		chk("silence wait", k >= 3990 && k < 4020, 1'b1);
		repeat (400) @(posedge ref_clk);
		chk("sends", n_tx, 2);
		force_delay <= 1'b1;
		@(posedge ref_clk);
		force_delay <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chk("forced delay", n_tx, 2);
		$display("test retry done");
		wr(`RMPC_IDX_INACT, 32'h0000_0002);
		wr(`RMPC_IDX_SLEEPSEL, 32'h0000_0001);
		repeat (20) @(posedge ref_clk);
		chk("asleep", asleep, 1'b1);
		wr(`RMPC_IDX_PINWAKE, 32'h0000_0001);
		mode_pin_3 <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("asleep", asleep, 1'b0);
		mode_pin_3 <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("asleep", asleep, 1'b1);
		wr(`RMPC_IDX_PWRUP, 32'h0000_0001);
		mode_pin_3 <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("cmd_mode", cmd_mode, 1'b1);
		mode_pin_3 <= 1'b1;
		wr(`RMPC_IDX_CTRL, 32'h0000_0002);
		wr(`RMPC_IDX_SLEEPSEL, 32'h0000_0000);
		$display("test sleep done");
		wr(`RMPC_IDX_PWRUP, 32'h0000_0001);
		wr(`RMPC_IDX_CTRL, 32'h0000_0001);
		wr(`RMPC_IDX_RESTORE, 32'h0000_0000);
		rd("mask", `RMPC_IDX_MASK, 32'h0000_FFFF);
		rd("pwrup", `RMPC_IDX_PWRUP, 32'h0000_0000);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		rd("pwrup", `RMPC_IDX_PWRUP, 32'h0000_0001);
		chk("cmd_mode", cmd_mode, 1'b1);
		$display("test persist done");
		give_verdict();
	end
endmodule
bind rmpc_top rmpc_top_assertions rmpc_top_assertions_inst (.*);
